/* File: sicd_params.svh */
// constants for the storage I/O command decoder
`ifndef SICD_PARAMS_SVH
`define SICD_PARAMS_SVH
`define SICD_OP_FLUSH 8'h00
`define SICD_OP_WRITE 8'h01
`define SICD_OP_READ 8'h02
`define SICD_OP_WRUNC 8'h04
`define SICD_OP_COMPARE 8'h05
`define SICD_OP_WRZERO 8'h08
`define SICD_OP_DSM 8'h09
`define SICD_OP_RSVREG 8'h0D
`define SICD_OP_RSVRPT 8'h0E
`define SICD_OP_RSVACQ 8'h11
`define SICD_OP_RSVREL 8'h15
`define SICD_VENDOR_BIT 7
`define SICD_FUNC_HI 6
`define SICD_FUNC_LO 2
`define SICD_DIR_HI 1
`define SICD_DIR_LO 0
`define SICD_MIN_LBA_SHIFT 9
`define SICD_SC_SUCCESS 8'h00
`define SICD_SC_INVALID_OPCODE 8'h01
`define SICD_SC_INVALID_FIELD 8'h02
`define SICD_SC_FUSED_FAILED 8'h09
`define SICD_SC_INVALID_FUSE 8'h0A
`define SICD_SC_INVALID_NS 8'h0B
`define SICD_SC_LBA_RANGE 8'h80
`define SICD_SC_COMPARE_FAIL 8'h85
`define SICD_SC_ATOMIC_EXCEEDED 8'h14
`define SICD_FUSE_NONE 2'h0
`define SICD_FUSE_FIRST 2'h1
`define SICD_FUSE_SECOND 2'h2
`endif

/* File: sicd_pkg.sv */
// types for the storage I/O command decoder
package sicd_pkg;
  typedef enum logic [1:0] {
    SICD_DIR_NONE = 2'h0,
    SICD_DIR_TO_CTRL = 2'h1,
    SICD_DIR_TO_HOST = 2'h2,
    SICD_DIR_BIDIR = 2'h3
  } sicd_dir_t;

  typedef struct packed {
    logic [15:0] cmdId;
    logic [7:0] opcode;
    logic [1:0] fuse;
    logic [31:0] nsId;
    logic [63:0] startLba;
    logic [15:0] blockCount;
    logic limitedRetry;
    logic [15:0] queueId;
  } sicd_cmd_t;

  typedef struct packed {
    logic [15:0] cmdId;
    logic [15:0] queueId;
    logic [7:0] status;
  } sicd_cpl_t;

  typedef struct packed {
    logic vendor;
    logic [4:0] func;
    sicd_dir_t dir;
  } sicd_opfield_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] nsId;
    logic [63:0] startLba;
    logic [15:0] blockCount;
    logic limitedRetry;
    logic fusedWrite;
  } sicd_exec_t;
endpackage : sicd_pkg

/* File: sicd_decoder.sv */
// command decode, namespace check and fused compare-write control
`timescale 1ns/1ps
`include "sicd_params.svh"
module sicd_decoder
  import sicd_pkg::*;
#(
  parameter int NS_COUNT = 4,
  parameter int LBA_SHIFT = 9
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // configuration
  input wire logic ctrlReady,
  input wire logic [3:0] optEnable,
  input wire logic rsvSupported,
  input wire logic [NS_COUNT-1:0] nsActive,
  input wire logic [NS_COUNT*64-1:0] nsSizeFlat,
  input wire logic [15:0] acwuBlocks,
  input wire logic atomicCheckEn,
  // command intake
  input wire logic cmdValid,
  output logic cmdReady,
  input wire sicd_cmd_t cmdIn,
  // execution engine
  output logic execValid,
  input wire logic execReady,
  output sicd_exec_t execOut,
  output logic [LBA_SHIFT:0] blockBytes,
  input wire logic execDone,
  input wire logic [7:0] execStatus,
  input wire logic compareMatch,
  // completion
  output logic cplValid,
  input wire logic cplReady,
  output sicd_cpl_t cplOut,
  // status
  output logic fusedPending,
  output logic vendorSeen
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // block size is a power of two, never below 512 bytes
  initial begin
    if (LBA_SHIFT < `SICD_MIN_LBA_SHIFT || LBA_SHIFT > 16) begin
      $error("block size shift out of range");
    end
    if (NS_COUNT < 1 || NS_COUNT > 1024) begin
      $error("namespace count out of range");
    end
  end
  assign blockBytes = {1'b1, {LBA_SHIFT{1'b0}}};

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // check slot of its own, so execOut already stands when execValid rises
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CHECK = 6'b000010,
    ST_EXEC = 6'b000100,
    ST_WAIT = 6'b001000,
    ST_CPL = 6'b010000,
    ST_CPL2 = 6'b100000
  } sicd_state_t;

  sicd_state_t state_reg, state_next;
  sicd_cmd_t cmd_reg;
  sicd_cmd_t cmpCmd_reg;
  logic haveCmp_reg;
  sicd_exec_t exec_reg;
  sicd_cpl_t cpl_reg, cpl2_reg;
  logic cpl2Pend_reg;
  logic writePhase_reg;
  logic vendor_reg;

  // ------------------------------------------------------------
  // opcode decode
  // ------------------------------------------------------------
  function automatic sicd_opfield_t split_op(input logic [7:0] op);
    sicd_opfield_t f;
    f.vendor = op[`SICD_VENDOR_BIT];
    f.func = op[`SICD_FUNC_HI:`SICD_FUNC_LO];
    f.dir = sicd_dir_t'(op[`SICD_DIR_HI:`SICD_DIR_LO]);
    return f;
  endfunction : split_op

  function automatic logic op_known(input logic [7:0] op, input logic [3:0] en,
                                    input logic rsv);
    logic k;
    k = 1'b0;
    case (op)
      `SICD_OP_FLUSH, `SICD_OP_WRITE, `SICD_OP_READ: k = 1'b1;
      `SICD_OP_WRUNC: k = en[0];
      `SICD_OP_COMPARE: k = en[1];
      `SICD_OP_WRZERO: k = en[2];
      `SICD_OP_DSM: k = en[3];
      `SICD_OP_RSVREG, `SICD_OP_RSVRPT, `SICD_OP_RSVACQ, `SICD_OP_RSVREL: k = rsv;
      default: k = 1'b0;
    endcase
    return k;
  endfunction : op_known

  sicd_opfield_t opf;
  wire logic isVendor;
  wire logic opOk;
  wire logic isCompare;
  wire logic isWrite;
  wire logic retryCmd;
  assign opf = split_op(cmd_reg.opcode);
  assign isVendor = opf.vendor;
  assign opOk = op_known(cmd_reg.opcode, optEnable, rsvSupported);
  assign isCompare = cmd_reg.opcode == `SICD_OP_COMPARE;
  assign isWrite = cmd_reg.opcode == `SICD_OP_WRITE;
  assign retryCmd = isCompare || isWrite || cmd_reg.opcode == `SICD_OP_READ ||
                    cmd_reg.opcode == `SICD_OP_WRZERO;

  // ------------------------------------------------------------
  // namespace checks
  // ------------------------------------------------------------
  // namespace ids are 1-based; any queue may reach any of them
  wire logic [31:0] nsIdx;
  wire logic nsValid;
  wire logic nsIsActive;
  logic [63:0] nsSize;
  wire logic [64:0] lbaEnd;
  wire logic lbaOk;
  wire logic needsNs;
  assign nsIdx = cmd_reg.nsId - 32'h00000001;
  assign nsValid = cmd_reg.nsId != 32'h00000000 && nsIdx < 32'(NS_COUNT);
  assign nsIsActive = nsValid && nsActive[nsIdx[9:0] % NS_COUNT];
  always_comb begin
    nsSize = 64'h0;
    if (nsValid) begin
      nsSize = nsSizeFlat[(nsIdx[9:0] % NS_COUNT)*64 +: 64];
    end
  end
  // zero-based count: blocks = blockCount + 1, last lba must be below size
  assign lbaEnd = {1'b0, cmd_reg.startLba} + {49'h0, cmd_reg.blockCount} + 65'h1;
  assign needsNs = cmd_reg.opcode != `SICD_OP_FLUSH && cmd_reg.opcode != `SICD_OP_DSM &&
                   !isVendor && opf.func[4:3] == 2'h0;
  assign lbaOk = !needsNs || lbaEnd <= {1'b0, nsSize};

  // ------------------------------------------------------------
  // fused pairing and check verdict
  // ------------------------------------------------------------
  wire logic fuseFirst;
  wire logic fuseSecond;
  wire logic fuseBad;
  wire logic pairMismatch;
  wire logic atomicBad;
  logic [7:0] checkStatus;
  assign fuseFirst = cmd_reg.fuse == `SICD_FUSE_FIRST;
  assign fuseSecond = cmd_reg.fuse == `SICD_FUSE_SECOND;
  // only compare first, write second is a legal pair
  assign fuseBad = (fuseFirst && !isCompare) || (fuseSecond && (!isWrite || !haveCmp_reg)) ||
                   (!fuseSecond && haveCmp_reg);
  assign pairMismatch = fuseSecond && haveCmp_reg &&
                        (cmd_reg.startLba != cmpCmd_reg.startLba ||
                         cmd_reg.blockCount != cmpCmd_reg.blockCount);
  assign atomicBad = atomicCheckEn && fuseSecond &&
                     ({1'b0, cmd_reg.blockCount} + 17'h1) > {1'b0, acwuBlocks};

  always_comb begin
    checkStatus = `SICD_SC_SUCCESS;
    if (!isVendor && !opOk) begin
      checkStatus = `SICD_SC_INVALID_OPCODE;
    end else if (fuseBad || pairMismatch) begin
      checkStatus = `SICD_SC_INVALID_FUSE;
    end else if (!nsValid) begin
      checkStatus = `SICD_SC_INVALID_NS;
    end else if (!nsIsActive) begin
      checkStatus = `SICD_SC_INVALID_FIELD;
    end else if (!lbaOk) begin
      checkStatus = `SICD_SC_LBA_RANGE;
    end else if (atomicBad) begin
      checkStatus = `SICD_SC_ATOMIC_EXCEEDED;
    end
  end

  // ------------------------------------------------------------
  // control
  // ------------------------------------------------------------
  // one command at a time, no lba ordering kept: host orders what it needs
  wire logic checkOk;
  wire logic cmpFailed;
  wire logic take;
  wire logic pairBroken;
  wire logic [7:0] heldStatus;
  sicd_exec_t execLoad;
  sicd_cpl_t ownCpl;
  sicd_cpl_t heldCpl;
  sicd_cpl_t cmpCpl;
  sicd_cpl_t failWrCpl;
  sicd_cpl_t doneWrCpl;
  assign checkOk = checkStatus == `SICD_SC_SUCCESS;
  assign cmpFailed = !compareMatch || execStatus != `SICD_SC_SUCCESS;
  assign take = cmdValid && cmdReady;
  // a held compare that cannot pair is answered ahead of the breaker
  assign pairBroken = haveCmp_reg && !checkOk;
  assign heldStatus = checkStatus == `SICD_SC_ATOMIC_EXCEEDED ? `SICD_SC_ATOMIC_EXCEEDED :
                      `SICD_SC_FUSED_FAILED;
  // single command in flight keeps every write whole to readers
  assign cmdReady = clkEn && state_reg == ST_IDLE;
  assign execValid = state_reg == ST_EXEC;
  assign execOut = exec_reg;
  assign cplValid = state_reg == ST_CPL || state_reg == ST_CPL2;
  assign cplOut = state_reg == ST_CPL2 ? cpl2_reg : cpl_reg;
  assign fusedPending = haveCmp_reg;
  assign vendorSeen = vendor_reg;

  // ------------------------------------------------------------
  // engine request and completion words
  // ------------------------------------------------------------
  // fused second first runs as a compare; the write follows on a match
  assign execLoad = '{opcode: fuseSecond ? `SICD_OP_COMPARE : cmd_reg.opcode,
                      nsId: cmd_reg.nsId,
                      startLba: cmd_reg.startLba,
                      blockCount: cmd_reg.blockCount,
                      limitedRetry: retryCmd & cmd_reg.limitedRetry,
                      fusedWrite: fuseSecond};
  assign ownCpl = '{cmdId: cmd_reg.cmdId, queueId: cmd_reg.queueId, status: checkStatus};
  assign heldCpl = '{cmdId: cmpCmd_reg.cmdId, queueId: cmpCmd_reg.queueId,
                     status: heldStatus};
  assign cmpCpl = '{cmdId: cmpCmd_reg.cmdId, queueId: cmpCmd_reg.queueId,
                    status: cmpFailed ? `SICD_SC_COMPARE_FAIL : `SICD_SC_SUCCESS};
  assign failWrCpl = '{cmdId: cmd_reg.cmdId, queueId: cmd_reg.queueId,
                       status: `SICD_SC_FUSED_FAILED};
  assign doneWrCpl = '{cmdId: cmd_reg.cmdId, queueId: cmd_reg.queueId, status: execStatus};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!checkOk) begin
          state_next = ST_CPL;
        end else if (fuseFirst) begin
          state_next = ST_IDLE;
        end else begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (execReady) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (execDone) begin
          state_next = (exec_reg.fusedWrite && !cmpFailed) ? ST_EXEC : ST_CPL;
        end
      end
      ST_CPL: begin
        if (cplReady) begin
          state_next = cpl2Pend_reg ? ST_CPL2 : ST_IDLE;
        end
      end
      ST_CPL2: begin
        if (cplReady) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cmd_reg <= '0;
      cmpCmd_reg <= '0;
      haveCmp_reg <= 1'b0;
      exec_reg <= '0;
      cpl_reg <= '0;
      cpl2_reg <= '0;
      cpl2Pend_reg <= 1'b0;
      writePhase_reg <= 1'b0;
      vendor_reg <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      if (take) begin
        cmd_reg <= cmdIn;
      end
      if (state_reg == ST_CHECK) begin
        vendor_reg <= vendor_reg | isVendor;
        exec_reg <= execLoad;
        haveCmp_reg <= checkOk && fuseFirst;
        cpl2Pend_reg <= pairBroken;
        writePhase_reg <= 1'b0;
        if (checkOk && fuseFirst) begin
          cmpCmd_reg <= cmd_reg;
        end
        if (pairBroken) begin
          cpl_reg <= heldCpl;
          cpl2_reg <= ownCpl;
        end else begin
          cpl_reg <= ownCpl;
        end
      end
      if (state_reg == ST_WAIT && execDone) begin
        if (exec_reg.fusedWrite) begin
          // compare answer fixed here, the write cannot change it
          cpl_reg <= cmpCpl;
          if (cmpFailed) begin
            cpl2_reg <= failWrCpl;
            cpl2Pend_reg <= 1'b1;
          end else begin
            exec_reg.opcode <= `SICD_OP_WRITE;
            exec_reg.fusedWrite <= 1'b0;
            writePhase_reg <= 1'b1;
          end
        end else if (writePhase_reg) begin
          cpl2_reg <= doneWrCpl;
          cpl2Pend_reg <= 1'b1;
          writePhase_reg <= 1'b0;
        end else begin
          cpl_reg.status <= execStatus;
        end
      end
      if (state_reg == ST_CPL2 && cplReady) begin
        cpl2Pend_reg <= 1'b0;
      end
    end
  end

endmodule : sicd_decoder

/* File: sicd_engine_model.sv */
// execution engine stand-in facing the command decoder
`timescale 1ns/1ps
module sicd_engine_model
  import sicd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // engine handshake
  input wire logic execValid,
  output logic execReady,
  input wire sicd_exec_t execOut,
  output logic execDone,
  output logic [7:0] execStatus,
  output logic compareMatch,
  // scenario control
  input wire logic matchSel,
  input wire logic [7:0] writeStat,
  input wire logic slow
);
  sicd_exec_t lastExec;
  int nIssued;
  int cnt;
  always @(posedge mclk) begin
    execDone <= 1'b0;
    // junk outside done, so nothing leans on stale values
    execStatus <= ~execStatus;
    compareMatch <= ~compareMatch;
    if (sys_rst) begin
      execReady <= 1'b0;
      execStatus <= 8'h00;
      compareMatch <= 1'b0;
      cnt <= 0;
      nIssued <= 0;
    end else if (execValid && execReady) begin
      execReady <= 1'b0;
      lastExec <= execOut;
      nIssued <= nIssued + 1;
      cnt <= slow ? 6 : 1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      execDone <= 1'b1;
      execStatus <= (lastExec.opcode == 8'h01) ? writeStat : 8'h00;
      compareMatch <= matchSel;
    end else begin
      execReady <= execValid;
    end
  end
endmodule : sicd_engine_model

/* File: sicd_decoder_sva.sv */
// protocol checker for the command decoder ports
`timescale 1ns/1ps
module sicd_decoder_chk
  import sicd_pkg::*;
#(
  parameter int NS_COUNT = 4,
  parameter int LBA_SHIFT = 9
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire sicd_cmd_t cmdIn,
  input wire logic execValid,
  input wire logic execReady,
  input wire sicd_exec_t execOut,
  input wire logic [LBA_SHIFT:0] blockBytes,
  input wire logic execDone,
  input wire logic [7:0] execStatus,
  input wire logic cplValid,
  input wire logic cplReady,
  input wire sicd_cpl_t cplOut,
  input wire logic vendorSeen
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire take = cmdValid && cmdReady && clkEn;
  single_cmd_a: assert property (take |=> !cmdReady)
    else $error("command accepted while busy");
  reserved_abort_a: assert property (take && cmdIn.opcode == 8'h03 |-> ##2 cplValid && cplOut.status == 8'h01)
    else $error("reserved opcode not aborted");
  reserved_noexec_a: assert property (take && cmdIn.opcode == 8'h03 |=> !execValid [*2])
    else $error("reserved opcode reached engine");
  bad_ns_a: assert property (take && cmdIn.opcode == 8'h02 && cmdIn.fuse == 2'h0 && cmdIn.nsId == 32'h0
    |-> ##2 cplValid && cplOut.status == 8'h0B)
    else $error("namespace zero not aborted");
  exec_hold_a: assert property (execValid && !execReady |=> execValid && $stable(execOut))
    else $error("engine request dropped or changed");
  cpl_hold_a: assert property (cplValid && !cplReady |=> cplValid && $stable(cplOut))
    else $error("completion dropped or changed");
  read_cpl_a: assert property (execDone && execOut.opcode == 8'h02
    |=> cplValid && cplOut.status == $past(execStatus))
    else $error("read completion missing or wrong status");
  vendor_flag_a: assert property (take && cmdIn.opcode[7] |-> ##2 vendorSeen)
    else $error("vendor command not flagged");
  block_size_a: assert property (blockBytes == {1'b1, {LBA_SHIFT{1'b0}}})
    else $error("block size not a power of two");
endmodule : sicd_decoder_chk
bind sicd_decoder sicd_decoder_chk #(.NS_COUNT(NS_COUNT), .LBA_SHIFT(LBA_SHIFT)) uChk (
  .mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .cmdIn(cmdIn), .execValid(execValid), .execReady(execReady), .execOut(execOut),
  .blockBytes(blockBytes), .execDone(execDone), .execStatus(execStatus), .cplValid(cplValid),
  .cplReady(cplReady), .cplOut(cplOut), .vendorSeen(vendorSeen));

/* File: sicd_testbench.sv */
// self-checking bench for the command decoder
`timescale 1ns/1ps
module testbench;
  import sicd_pkg::*;
  logic mclk, sys_rst, clkEn, ctrlReady, rsvSupported, atomicCheckEn, cmdValid, cmdReady;
  logic execValid, execReady, execDone, compareMatch, cplValid, cplReady, fusedPending;
  logic vendorSeen, matchSel, slow;
  logic [3:0] optEnable, nsActive;
  logic [255:0] nsSizeFlat;
  logic [15:0] acwuBlocks, seq;
  logic [7:0] execStatus, writeStat;
  logic [9:0] blockBytes;
  sicd_cmd_t cmdIn, c;
  sicd_exec_t execOut;
  sicd_cpl_t cplOut, r0;
  int nFail = 0;
  int totalChecks = 0;
  localparam logic [7:0] OPS [12] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0D,
    8'h0E, 8'h11, 8'h15, 8'h03};
  sicd_decoder #(.NS_COUNT(4), .LBA_SHIFT(9)) uut (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
    .ctrlReady(ctrlReady), .optEnable(optEnable), .rsvSupported(rsvSupported),
    .nsActive(nsActive), .nsSizeFlat(nsSizeFlat), .acwuBlocks(acwuBlocks),
    .atomicCheckEn(atomicCheckEn), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdIn(cmdIn),
    .execValid(execValid), .execReady(execReady), .execOut(execOut), .blockBytes(blockBytes),
    .execDone(execDone), .execStatus(execStatus), .compareMatch(compareMatch),
    .cplValid(cplValid), .cplReady(cplReady), .cplOut(cplOut), .fusedPending(fusedPending),
    .vendorSeen(vendorSeen));
  sicd_engine_model uEng (.mclk(mclk), .sys_rst(sys_rst), .execValid(execValid),
    .execReady(execReady), .execOut(execOut), .execDone(execDone), .execStatus(execStatus),
    .compareMatch(compareMatch), .matchSel(matchSel), .writeStat(writeStat), .slow(slow));
  always #20 mclk = ~mclk;
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  task automatic endSim;
    $display("checks=%0d mismatches=%0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : endSim
  function automatic sicd_cmd_t mk(input logic [7:0] op, input logic [1:0] fu,
      input logic [31:0] ns, input logic [63:0] lba, input logic [15:0] bc);
    seq++;
    return '{cmdId: seq, opcode: op, fuse: fu, nsId: ns, startLba: lba, blockCount: bc,
      limitedRetry: seq[0], queueId: ~seq};
  endfunction : mk
  // request held until cmdReady seen; negedge sample equals edge value
  task automatic send(input sicd_cmd_t cc);
    int k;
    logic r;
    k = 0;
    r = 1'b0;
    @(posedge mclk);
    cmdIn <= cc;
    cmdValid <= 1'b1;
    while (!r && k < 60) begin
      @(negedge mclk);
      r = cmdReady;
      k++;
      @(posedge mclk);
    end
    cmdValid <= 1'b0;
    if (!r) nFail++;
  endtask : send
  // one stall cycle first, so the completion must stand
  task automatic getCpl(output sicd_cpl_t r);
    int k;
    logic v;
    k = 0;
    v = 1'b0;
    while (!v && k < 200) begin
      @(negedge mclk);
      v = cplValid;
      r = cplOut;
      k++;
    end
    @(posedge mclk);
    cplReady <= 1'b1;
    @(posedge mclk);
    cplReady <= 1'b0;
    if (!v) nFail++;
  endtask : getCpl
  task automatic run(input sicd_cmd_t cc, input logic [7:0] ex);
    sicd_cpl_t r;
    send(cc);
    getCpl(r);
    chk({r.cmdId, r.queueId, r.status}, {cc.cmdId, cc.queueId, ex});
  endtask : run
  task automatic fused(input logic m, input logic [15:0] bc, input logic [7:0] sc,
      input logic [7:0] sw, input int iss);
    sicd_cmd_t a, b;
    sicd_cpl_t r;
    int n0;
    n0 = uEng.nIssued;
    matchSel <= m;
    a = mk(8'h05, 2'h1, 32'h1, 64'h8, bc);
    b = mk(8'h01, 2'h2, 32'h1, 64'h8, bc);
    send(a);
    repeat (2) @(negedge mclk);
    chk(fusedPending, 1'b1);
    send(b);
    getCpl(r);
    chk({r.cmdId, r.status}, {a.cmdId, sc});
    getCpl(r);
    chk({r.cmdId, r.status}, {b.cmdId, sw});
    chk(uEng.nIssued - n0, iss);
  endtask : fused
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    nFail++;
    endSim();
  end
  initial begin
    {mclk, cmdValid, cplReady, ctrlReady, rsvSupported, atomicCheckEn, slow} = 7'h00;
    {sys_rst, clkEn, matchSel} = 3'h7;
    optEnable = 4'h0;
    writeStat = 8'h00;
    cmdIn = '0;
    seq = 16'h0000;
    nsActive = 4'hD;
    nsSizeFlat = {4{64'h40}};
    acwuBlocks = 16'h4;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    ctrlReady <= 1'b1;
    @(negedge mclk);
    chk({cplValid, execValid, cmdReady, vendorSeen}, 4'h2);
    chk(blockBytes, 10'h200);
    @(posedge mclk);
    clkEn <= 1'b0;
    @(negedge mclk);
    chk(cmdReady, 1'b0);
    @(posedge mclk);
    clkEn <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk);
      optEnable <= m ? 4'hF : 4'h0;
      rsvSupported <= m[0];
      slow <= m[0];
      for (int i = 0; i < 12; i++) begin
        run(mk(OPS[i], 2'h0, 32'h1, 64'h0, 16'h0), (i == 11 || (m == 0 && i > 2)) ? 8'h01 : 8'h00);
      end
    end
    for (int j = 0; j < 2; j++) begin
      c = mk(8'h02, 2'h0, 32'h4, 64'h7 + j, 16'h3);
      run(c, 8'h00);
      chk({uEng.lastExec.opcode, uEng.lastExec.nsId, uEng.lastExec.startLba,
        uEng.lastExec.blockCount, uEng.lastExec.limitedRetry}, {c.opcode, c.nsId, c.startLba,
        c.blockCount, c.limitedRetry});
    end
    run(mk(8'h02, 2'h0, 32'h0, 64'h0, 16'h0), 8'h0B);
    run(mk(8'h02, 2'h0, 32'h5, 64'h0, 16'h0), 8'h0B);
    run(mk(8'h02, 2'h0, 32'h2, 64'h0, 16'h0), 8'h02);
    run(mk(8'h01, 2'h0, 32'h3, 64'h3F, 16'h0), 8'h00);
    run(mk(8'h02, 2'h0, 32'h1, 64'h3F, 16'h1), 8'h80);
    run(mk(8'h02, 2'h0, 32'h1, 64'h40, 16'h0), 8'h80);
    run(mk(8'h01, 2'h2, 32'h1, 64'h0, 16'h0), 8'h0A);
    run(mk(8'h02, 2'h1, 32'h1, 64'h0, 16'h0), 8'h0A);
    send(mk(8'hC1, 2'h0, 32'h1, 64'h0, 16'h0));
    getCpl(r0);
    chk(r0.status, 8'h00);
    chk(vendorSeen, 1'b1);
    fused(1'b1, 16'h3, 8'h00, 8'h00, 2);
    fused(1'b0, 16'h3, 8'h85, 8'h09, 1);
    writeStat <= 8'h81;
    fused(1'b1, 16'h3, 8'h00, 8'h81, 2);
    writeStat <= 8'h00;
    atomicCheckEn <= 1'b1;
    fused(1'b1, 16'h3, 8'h00, 8'h00, 2);
    fused(1'b1, 16'h4, 8'h14, 8'h14, 0);
    endSim();
  end
endmodule : testbench
